// ==== src/seq_pkg.sv ====
// constants, register map and state encodings of the transmit/receive sequencer
package seq_pkg;

  // system clock period and the base tick that all standby delays count in
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_PERIOD_US = 500;
  localparam int TICK_CYCLES_DEF = (TICK_PERIOD_US * 1000) / CLK_PERIOD_NS;

  // delay figures in microseconds
  localparam int CARRIER_ON_DELAY_US = 10000;
  localparam int TX_RELEASE_US = 5000;
  localparam int TX_RELEASE_CW_US = 12500;
  localparam int CARRIER_OFF_CW_US = 8500;
  localparam int UNMUTE_DELAY_US = 12500;

  // the same delays as whole ticks; least times round up
  localparam int TW = 16;
  localparam logic [TW-1:0] CARRIER_ON_TICKS =
    TW'((CARRIER_ON_DELAY_US + TICK_PERIOD_US - 1) / TICK_PERIOD_US);
  localparam logic [TW-1:0] TX_RELEASE_TICKS =
    TW'((TX_RELEASE_US + TICK_PERIOD_US - 1) / TICK_PERIOD_US);
  localparam logic [TW-1:0] TX_RELEASE_CW_TICKS =
    TW'((TX_RELEASE_CW_US + TICK_PERIOD_US - 1) / TICK_PERIOD_US);
  localparam logic [TW-1:0] CARRIER_OFF_CW_TICKS =
    TW'((CARRIER_OFF_CW_US + TICK_PERIOD_US - 1) / TICK_PERIOD_US);
  localparam logic [TW-1:0] UNMUTE_TICKS =
    TW'((UNMUTE_DELAY_US + TICK_PERIOD_US - 1) / TICK_PERIOD_US);

  // register map, byte addresses on the 32-bit bus
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CONTROL_OFFSET = 4'h0;
  localparam logic [ADDR_W-1:0] VOX_DELAY_OFFSET = 4'h4;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h8;

  // control register fields
  localparam int CTL_CW_MODE_BIT = 0;
  localparam int CTL_VOX_EN_BIT = 1;
  localparam int CTL_SEMI_BIT = 2;
  localparam int CTL_W = 3;
  localparam logic [CTL_W-1:0] CONTROL_RESET = 3'h0;

  // hang time of semi break-in, in ticks
  localparam logic [TW-1:0] VOX_DELAY_RESET = 16'h0190;

  // status register fields
  localparam int ST_TX_BIT = 0;
  localparam int ST_RX_BIT = 1;
  localparam int ST_CARRIER_BIT = 2;
  localparam int ST_UNMUTE_N_BIT = 3;
  localparam int ST_KEY_BIT = 4;
  localparam int ST_INHIBIT_N_BIT = 5;
  localparam int ST_HOLD_BIT = 6;
  localparam int ST_W = 7;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    SEQ_RX = 3'b001,
    SEQ_TX = 3'b010,
    SEQ_HANG = 3'b100
  } seq_state_t;

endpackage

// ==== src/tick_delay.sv ====
// delay timer: counts whole ticks from the moment its enable rises
`timescale 1ns/100ps
module tick_delay #(
  parameter int TICK_CYCLES = seq_pkg::TICK_CYCLES_DEF
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic enable,
  input wire logic [seq_pkg::TW-1:0] length,
  output logic done
);
  import seq_pkg::*;

  // own prescaler restarts with enable, so the delay is exact, not tick-jittered
  logic [15:0] pre_q;
  logic [15:0] pre_d;
  logic [TW-1:0] cnt_q;
  logic [TW-1:0] cnt_d;

  assign done = enable && (cnt_q == length);

  always_comb begin
    pre_d = pre_q;
    cnt_d = cnt_q;
    if (!enable) begin
      pre_d = 16'h0000;
      cnt_d = '0;
    end else if (cnt_q != length) begin
      if (pre_q == 16'(TICK_CYCLES - 1)) begin
        pre_d = 16'h0000;
        cnt_d = cnt_q + 1'b1;
      end else begin
        pre_d = pre_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pre_q <= 16'h0000;
      cnt_q <= '0;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
    end
  end

endmodule

// ==== src/transmit_receive_sequencer.sv ====
// transmit/receive standby sequencer with its AXI4-Lite register slave
//
// What this block does
// - after manual non-cw standby release, receive_unmute_n goes low only 17.5 ms later.
// - manual standby raises carrier_keying 10 ms after transmit_active rises.
// - receive_unmute_n stays high 12.5 ms after receive_active rises, then low.
// - full break-in with vox raises transmit_active at key press if tx_inhibit_n high.
// - full break-in raises carrier_keying 10 ms after key press.
// - in cw full break-in transmit_active falls 12.5 ms after key release.
// - in cw mode carrier_keying holds 8.5 ms after key release.
// - after cw key release receive unmutes 12.5 ms after transmit_active falls, as manual standby.
// - semi break-in key press sets a hold that lasts the vox delay setting after key release.
// - semi break-in hold asserts transmit_active only while vox is enabled.
// - semi break-in raises carrier_keying 10 ms after key press.
// - semi break-in drops carrier_keying 8.5 ms after key release.
// - terminal_standby_n low acts exactly like a manual standby request.
// - transmit_active never asserts while tx_inhibit_n is low.
// - manual non-cw release drops transmit_active 5 ms later, receive_active rises.
// - manual non-cw release drops carrier_keying at once.
// - receive_active is always the complement of transmit_active.
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
module transmit_receive_sequencer #(
  parameter int TICK_CYCLES = seq_pkg::TICK_CYCLES_DEF
) (
  input wire logic clk_sys,
  input wire logic resetn,
  // standby and keying pins; the inputs and receive_unmute_n are active low
  input wire logic standby_n,
  input wire logic key_n,
  input wire logic tx_inhibit_n,
  input wire logic terminal_standby_n,
  output logic transmit_active,
  output logic receive_active,
  output logic carrier_keying,
  output logic receive_unmute_n,
  // AXI4-Lite slave
  input wire logic [seq_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [seq_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import seq_pkg::*;

  // ---------------- register slave ----------------
  logic aw_held_q, aw_held_d;
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic w_held_q, w_held_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [CTL_W-1:0] control_q, control_d;
  logic [TW-1:0] vox_delay_q, vox_delay_d;
  logic [ST_W-1:0] status;

  // sequencer state, declared here because the status word reads it
  seq_state_t state_q, state_d;
  logic tx_q, tx_d;
  logic rx_q, rx_d;
  logic carrier_q, carrier_d;
  logic unmute_n_q, unmute_n_d;
  logic hold_q, hold_d;

  logic cw_mode_active;
  logic vox_enable;
  logic semi_break_in;

  assign cw_mode_active = control_q[CTL_CW_MODE_BIT];
  assign vox_enable = control_q[CTL_VOX_EN_BIT];
  assign semi_break_in = control_q[CTL_SEMI_BIT];

  assign awready = !aw_held_q && !bvalid_q;
  assign wready = !w_held_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;

  always_comb begin
    status = '0;
    status[ST_TX_BIT] = tx_q;
    status[ST_RX_BIT] = rx_q;
    status[ST_CARRIER_BIT] = carrier_q;
    status[ST_UNMUTE_N_BIT] = unmute_n_q;
    status[ST_KEY_BIT] = !key_n;
    status[ST_INHIBIT_N_BIT] = tx_inhibit_n;
    status[ST_HOLD_BIT] = hold_q;
  end

  always_comb begin
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    w_held_d = w_held_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    control_d = control_q;
    vox_delay_d = vox_delay_q;
    // address and data may arrive in either order; each is held until both are in
    if (awvalid && awready) begin
      aw_held_d = 1'b1;
      aw_addr_d = awaddr;
    end
    if (wvalid && wready) begin
      w_held_d = 1'b1;
      w_data_d = wdata;
      w_strb_d = wstrb;
    end
    if (aw_held_q && w_held_q && !bvalid_q) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      unique case (aw_addr_q)
        CONTROL_OFFSET: begin
          if (w_strb_q[0]) begin
            control_d = w_data_q[CTL_W-1:0];
          end
        end
        VOX_DELAY_OFFSET: begin
          if (w_strb_q[0]) begin
            vox_delay_d[7:0] = w_data_q[7:0];
          end
          if (w_strb_q[1]) begin
            vox_delay_d[15:8] = w_data_q[15:8];
          end
        end
        // status is read only; a write there is accepted and ignored
        STATUS_OFFSET: begin
        end
        default: begin
          bresp_d = RESP_DECERR;
        end
      endcase
    end else if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = 32'h00000000;
      unique case (araddr)
        CONTROL_OFFSET: rdata_d[CTL_W-1:0] = control_q;
        VOX_DELAY_OFFSET: rdata_d[TW-1:0] = vox_delay_q;
        STATUS_OFFSET: rdata_d[ST_W-1:0] = status;
        default: rresp_d = RESP_DECERR;
      endcase
    end else if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
      w_held_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h00000000;
      control_q <= CONTROL_RESET;
      vox_delay_q <= VOX_DELAY_RESET;
    end else begin
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      w_held_q <= w_held_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      control_q <= control_d;
      vox_delay_q <= vox_delay_d;
    end
  end

  // ---------------- request decoding ----------------
  logic manual_request, key_down, break_request, request, keying_source;

  // the data terminal simply parallels the standby switch
  assign manual_request = !standby_n || !terminal_standby_n;
  // the key is only meaningful when the cw path is selected
  assign key_down = cw_mode_active && !key_n;

  always_comb begin
    break_request = 1'b0;
    if (cw_mode_active && vox_enable) begin
      if (semi_break_in) begin
        break_request = hold_q;
      end else begin
        break_request = key_down;
      end
    end
  end

  assign request = manual_request || break_request;
  // carrier follows the key or the standby request in cw, the standby request alone otherwise
  assign keying_source = manual_request || key_down;

  // ---------------- delay timers ----------------
  logic hold_done, release_done, carrier_on_done, carrier_off_done, unmute_done;
  logic [TW-1:0] release_len;

  // in cw mode a key-up or standby release hangs longer than a non-cw release
  assign release_len = cw_mode_active ? TX_RELEASE_CW_TICKS : TX_RELEASE_TICKS;

  // semi break-in hang runs from key release; a new press restarts it
  tick_delay #(.TICK_CYCLES(TICK_CYCLES)) hold_timer (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .enable(hold_q && !key_down),
    .length(vox_delay_q),
    .done(hold_done)
  );

  tick_delay #(.TICK_CYCLES(TICK_CYCLES)) release_timer (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .enable(state_q == SEQ_HANG),
    .length(release_len),
    .done(release_done)
  );

  // carrier waits 10 ms after transmit is up
  tick_delay #(.TICK_CYCLES(TICK_CYCLES)) carrier_on_timer (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .enable(keying_source && tx_q && !carrier_q),
    .length(CARRIER_ON_TICKS),
    .done(carrier_on_done)
  );

  tick_delay #(.TICK_CYCLES(TICK_CYCLES)) carrier_off_timer (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .enable(carrier_q && !keying_source && cw_mode_active),
    .length(CARRIER_OFF_CW_TICKS),
    .done(carrier_off_done)
  );

  // receive path stays muted 12.5 ms after receive comes back
  tick_delay #(.TICK_CYCLES(TICK_CYCLES)) unmute_timer (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .enable(rx_q && unmute_n_q),
    .length(UNMUTE_TICKS),
    .done(unmute_done)
  );

  // ---------------- sequencer ----------------
  always_comb begin
    state_d = state_q;
    hold_d = hold_q;
    if (key_down && semi_break_in) begin
      hold_d = 1'b1;
    end else if (hold_done || !semi_break_in) begin
      hold_d = 1'b0;
    end
    unique case (state_q)
      SEQ_RX: begin
        if (request && tx_inhibit_n) begin
          state_d = SEQ_TX;
        end
      end
      SEQ_TX: begin
        if (!tx_inhibit_n) begin
          state_d = SEQ_RX;
        end else if (!request) begin
          state_d = SEQ_HANG;
        end
      end
      SEQ_HANG: begin
        if (!tx_inhibit_n) begin
          state_d = SEQ_RX;
        end else if (request) begin
          state_d = SEQ_TX;
        end else if (release_done) begin
          state_d = SEQ_RX;
        end
      end
      default: begin
        state_d = SEQ_RX;
      end
    endcase
    tx_d = (state_d != SEQ_RX);
    rx_d = !tx_d;

    carrier_d = carrier_q;
    if (!tx_q || !tx_inhibit_n) begin
      carrier_d = 1'b0;
    end else if (!carrier_q) begin
      carrier_d = carrier_on_done;
    end else if (!keying_source) begin
      // cw keeps the carrier for the waveform tail; otherwise it drops at once
      if (cw_mode_active) begin
        carrier_d = !carrier_off_done;
      end else begin
        carrier_d = 1'b0;
      end
    end

    unmute_n_d = unmute_n_q;
    if (tx_q) begin
      unmute_n_d = 1'b1;
    end else if (unmute_done) begin
      unmute_n_d = 1'b0;
    end
  end

  // reset lands in plain receive with the receive path open
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_q <= SEQ_RX;
      tx_q <= 1'b0;
      rx_q <= 1'b1;
      carrier_q <= 1'b0;
      unmute_n_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      state_q <= state_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      carrier_q <= carrier_d;
      unmute_n_q <= unmute_n_d;
      hold_q <= hold_d;
    end
  end

  assign transmit_active = tx_q;
  assign receive_active = rx_q;
  assign carrier_keying = carrier_q;
  assign receive_unmute_n = unmute_n_q;

endmodule

// ==== tb/operator_panel.sv ====
// operator switches, key and processor inhibit line as seen by the sequencer
`timescale 1ns/100ps
module operator_panel (
  input wire logic sb_req,
  input wire logic term_req,
  input wire logic key_req,
  input wire logic allow,
  output logic standby_n,
  output logic terminal_standby_n,
  output logic key_n,
  output logic tx_inhibit_n
);
  // contacts ground their lines while closed
  assign standby_n = !sb_req;
  assign terminal_standby_n = !term_req;
  assign key_n = !key_req;
  // tx_inhibit_n follows allow, which the bench drives low while the processor holds the pins back
  assign tx_inhibit_n = allow;
endmodule

// ==== tb/seq_checker_sva.sv ====
// pin-level timing checks of the transmit/receive sequencer
`timescale 1ns/100ps
module seq_checker #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic standby_n,
  input wire logic key_n,
  input wire logic tx_inhibit_n,
  input wire logic terminal_standby_n,
  input wire logic transmit_active,
  input wire logic receive_active,
  input wire logic carrier_keying,
  input wire logic receive_unmute_n
);
  localparam int CARRIER_ON = 20 * TICK_CYCLES + 1;
  localparam int UNMUTE = 25 * TICK_CYCLES + 1;
  localparam int HANG = 10 * TICK_CYCLES;
  // cycles spent in each condition; saturate so a long idle never wraps to a small count
  logic [15:0] tx_cnt_q, tx_cnt_d, rx_cnt_q, rx_cnt_d, idle_cnt_q, idle_cnt_d;
  logic idle;

  always_comb begin
    idle = standby_n && terminal_standby_n && key_n;
    tx_cnt_d = transmit_active ? tx_cnt_q + {15'h0, ~&tx_cnt_q} : 16'h0;
    rx_cnt_d = receive_active ? rx_cnt_q + {15'h0, ~&rx_cnt_q} : 16'h0;
    idle_cnt_d = idle ? idle_cnt_q + {15'h0, ~&idle_cnt_q} : 16'h0;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tx_cnt_q <= 16'h0;
      rx_cnt_q <= 16'h0;
      idle_cnt_q <= 16'h0;
    end else begin
      tx_cnt_q <= tx_cnt_d;
      rx_cnt_q <= rx_cnt_d;
      idle_cnt_q <= idle_cnt_d;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  a_rx_complement: assert property (receive_active == !transmit_active)
    else $error("receive_active is not the complement of transmit_active");
  a_reset_rx: assert property (@(posedge clk_sys) disable iff (1'b0) !resetn |=>
    !transmit_active && receive_active && !carrier_keying && !receive_unmute_n)
    else $error("outputs not in receive state after reset");
  a_inhibit_block: assert property (!tx_inhibit_n |=> !transmit_active && !carrier_keying)
    else $error("transmit while inhibited");
  // sampled reset in the antecedent: the first edge after release still sees the reset state
  a_request_tx: assert property (resetn && (!standby_n || !terminal_standby_n)
    && tx_inhibit_n |=> transmit_active)
    else $error("standby request did not raise transmit_active");
  a_carrier_not_early: assert property ($rose(carrier_keying) |-> tx_cnt_q >= CARRIER_ON)
    else $error("carrier_keying rose too early");
  a_carrier_needs_tx: assert property (carrier_keying |-> transmit_active)
    else $error("carrier_keying high while receiving");
  a_unmute_delay: assert property ($fell(receive_unmute_n) |-> rx_cnt_q == UNMUTE)
    else $error("receive_unmute_n fell at the wrong time");
  a_muted_in_tx: assert property (transmit_active && $past(transmit_active)
    |-> receive_unmute_n)
    else $error("receive path open during transmit");
  a_unmute_rise: assert property ($rose(transmit_active) |-> ##[0:1] receive_unmute_n)
    else $error("receive path not muted on transmit");
  a_tx_hang: assert property ($fell(transmit_active) && tx_inhibit_n &&
    $past(tx_inhibit_n) |-> idle_cnt_q >= HANG)
    else $error("transmit_active fell before the release delay");

  c_carrier_up: cover property ($rose(carrier_keying));
  c_unmute: cover property ($fell(receive_unmute_n));
  c_blocked: cover property (!tx_inhibit_n && !standby_n);
endmodule

// ==== tb/transmit_receive_sequencer_tb.sv ====
// self-checking bench of the transmit/receive sequencer
`timescale 1ns/100ps
module transmit_receive_sequencer_tb;
  import seq_pkg::*;
  localparam int T = 4;
  typedef struct {logic [2:0] ctl; int src; int cky_off; int tx_off;} row_t;
  row_t rows [4];
  logic clk_sys, resetn = 1'b0, sb_req = 1'b0, term_req = 1'b0, key_req = 1'b0, allow = 1'b1;
  logic standby_n, key_n, tx_inhibit_n, terminal_standby_n;
  logic transmit_active, receive_active, carrier_keying, receive_unmute_n;
  logic [ADDR_W-1:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  int error_cnt = 0, n_tests = 0, a, b, c;

  operator_panel panel (.sb_req, .term_req, .key_req, .allow, .standby_n, .terminal_standby_n,
    .key_n, .tx_inhibit_n);
  transmit_receive_sequencer #(.TICK_CYCLES(T)) DUT (.clk_sys, .resetn, .standby_n, .key_n,
    .tx_inhibit_n, .terminal_standby_n, .transmit_active, .receive_active, .carrier_keying,
    .receive_unmute_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic axi_write(input logic [3:0] ad, input logic [31:0] da, output logic [1:0] rs);
    rs = 2'h2;
    @(posedge clk_sys);
    awaddr <= ad;
    wdata <= da;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_read(input logic [3:0] ad, output logic [31:0] da, output logic [1:0] rs);
    rs = 2'h2;
    da = 32'h0;
    @(posedge clk_sys);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        da = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic drive(input int src, input logic on);
    @(posedge clk_sys);
    if (src == 0) sb_req <= on;
    else if (src == 1) term_req <= on;
    else key_req <= on;
  endtask

  // edges from the drive edge until each output first reaches its target level
  task automatic watch(input logic want, output int ta, output int tb, output int tc);
    int k;
    ta = 0;
    tb = 0;
    tc = 0;
    k = 0;
    while ((ta == 0 || tb == 0 || tc == 0) && k < 1000) begin
      @(posedge clk_sys);
      #1;
      k++;
      if (ta == 0 && transmit_active === want) ta = k;
      if (tb == 0 && carrier_keying === want) tb = k;
      if (tc == 0 && receive_unmute_n === want) tc = k;
    end
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // the whole sequence needs about 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    complete_run();
  end

  initial begin
    rows = '{'{3'h0, 0, 1, 10 * T + 2}, '{3'h0, 1, 1, 10 * T + 2},
      '{3'h3, 2, 17 * T + 1, 25 * T + 2}, '{3'h1, 0, 17 * T + 1, 25 * T + 2}};
    repeat (5) @(posedge clk_sys);
    check({transmit_active, receive_active, carrier_keying, receive_unmute_n}, 4'h4);
    resetn <= 1'b1;
    axi_read(CONTROL_OFFSET, d, r);
    check(d, 32'h0);
    axi_read(VOX_DELAY_OFFSET, d, r);
    check(d, {16'h0, VOX_DELAY_RESET});
    axi_read(STATUS_OFFSET, d, r);
    check(d, 32'h22);
    axi_read(4'hC, d, r);
    check(r, RESP_DECERR);
    check(d, 32'h0);
    foreach (rows[i]) begin
      axi_write(CONTROL_OFFSET, {29'h0, rows[i].ctl}, r);
      check(r, RESP_OKAY);
      drive(rows[i].src, 1'b1);
      watch(1'b1, a, b, c);
      check(a, 1);
      check(b, 20 * T + 2);
      drive(rows[i].src, 1'b0);
      watch(1'b0, a, b, c);
      check(b, rows[i].cky_off);
      check(a, rows[i].tx_off);
      check(c - a, 25 * T + 1);
    end
    // inhibit held before the request, then released, then pulled in mid-transmit
    axi_write(CONTROL_OFFSET, 32'h0, r);
    allow <= 1'b0;
    drive(0, 1'b1);
    repeat (50) @(posedge clk_sys);
    check(transmit_active, 1'b0);
    allow <= 1'b1;
    watch(1'b1, a, b, c);
    check(a, 1);
    @(posedge clk_sys);
    allow <= 1'b0;
    @(posedge clk_sys);
    #1;
    check({transmit_active, carrier_keying}, 2'h0);
    drive(0, 1'b0);
    allow <= 1'b1;
    watch(1'b0, a, b, c);
    axi_write(VOX_DELAY_OFFSET, 32'h28, r);
    axi_write(CONTROL_OFFSET, 32'h7, r);
    drive(2, 1'b1);
    watch(1'b1, a, b, c);
    // the key is latched into the hold flag first, so transmit starts one clock later
    check(b, 20 * T + 3);
    drive(2, 1'b0);
    watch(1'b0, a, b, c);
    check(b, 17 * T + 1);
    check(a > 40 * T, 1'b1);
    axi_write(CONTROL_OFFSET, 32'h5, r);
    drive(2, 1'b1);
    repeat (20) @(posedge clk_sys);
    check(transmit_active, 1'b0);
    drive(2, 1'b0);
    axi_write(CONTROL_OFFSET, 32'h0, r);
    drive(0, 1'b1);
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check({transmit_active, receive_active, carrier_keying, receive_unmute_n}, 4'h4);
    @(posedge clk_sys);
    resetn <= 1'b1;
    drive(0, 1'b0);
    repeat (200) @(posedge clk_sys);
    complete_run();
  end
endmodule

bind transmit_receive_sequencer seq_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (.clk_sys,
  .resetn, .standby_n, .key_n, .tx_inhibit_n, .terminal_standby_n, .transmit_active,
  .receive_active, .carrier_keying, .receive_unmute_n);
